// [prp_panel_rx.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] Host clocks pixels near 25.18, below 28.33 MHz.
// [RULE2] Line period 750 to 900 pixel clocks.
// [RULE3] Line sync lasts 2 to 200 clocks.
// [RULE4] Frame holds 515 to 560 lines.
// [RULE5] Frame rate at least 50 Hz.
// [RULE6] Frame sync lasts 1 to 34 lines.
// [RULE7] Exactly 640 pixels accepted per line.
// [RULE8] Frame sync offset within line period.
// [RULE9] Vertical display starts 34 lines after sync.
// [RULE10] Enable high 2 clocks to period minus 10.
// [RULE11] Enable rises 44 to period-664 after sync.
// [RULE12] First pixel taken at enable rising edge.
// [RULE13] Enable held low: start at clock 104.
// [RULE14] Late or short enable: start at 104. The code starts on any enable rise before 104, however short.
// [RULE15] Six bits per colour, bit 0 least significant.
// [RULE16] Counters restart on their sync pulses.
module prp_panel_rx (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire prp_pkg::prp_pins_t pins,
    output logic pixel_valid,
    output prp_pkg::prp_rgb_t pixel_data,
    output prp_pkg::prp_pos_t pixel_pos,
    output logic frame_start
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        // Pin capture: three stages, the filtered copy and the pins as
        // they stood at the previous pixel clock edge.
        prp_pkg::prp_pins_t sync1;
        prp_pkg::prp_pins_t sync2;
        prp_pkg::prp_pins_t sync3;
        prp_pkg::prp_pins_t filt;
        prp_pkg::prp_pins_t last_px;
        // Pixel count in the line, line count in the frame, pixels drawn.
        logic [prp_pkg::COUNT_BITS-1:0] h_cnt;
        logic [prp_pkg::COUNT_BITS-1:0] v_cnt;
        logic [prp_pkg::COUNT_BITS-1:0] x_cnt;
        prp_pkg::prp_hstate_t hstate;
        // Registered outputs.
        logic valid;
        prp_pkg::prp_rgb_t data;
        prp_pkg::prp_pos_t pos;
        logic fstart;
    } prp_state_t;

    prp_state_t state_ff;
    prp_state_t nxt_state;

    // ************************************************************
    // Next state
    // ************************************************************
    // Pins are asynchronous to core_clk, so each bit runs through three
    // flops and a filtered copy only moves once stages two and three
    // agree. Everything after that works on pixel_clock rising edges
    // seen in the filtered copy, which limits the usable pixel rate to
    // well under a quarter of core_clk.
    // The filtered copy lags the pins by four cycles but keeps a single
    // unsettled sample from ever reaching the counters. Every pin takes
    // the same path, so data, syncs and enable stay lined up with the
    // pixel clock that samples them.
    always_comb
    begin
        logic px_edge;
        logic line_edge;
        logic frame_edge;
        logic enable_rise;
        logic v_active;
        logic start_now;
        prp_pkg::prp_pins_t p;
        prp_pkg::prp_pins_t agree;
        px_edge = 1'b0;
        line_edge = 1'b0;
        frame_edge = 1'b0;
        enable_rise = 1'b0;
        v_active = 1'b0;
        start_now = 1'b0;
        p = '0;
        agree = '0;
        nxt_state = state_ff;
        // Three capture stages for every pin bit.
        nxt_state.sync1 = pins;
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.sync3 = state_ff.sync2;
        // Only agreeing bits update; a bit in transit keeps its old value.
        agree = ~(state_ff.sync2 ^ state_ff.sync3);
        nxt_state.filt = (state_ff.filt & ~agree) | (state_ff.sync3 & agree);
        p = nxt_state.filt;
        // A rising pixel_clock in the filtered copy is the one moment at
        // which the other filtered pins are taken.
        px_edge = p.pixel_clock & ~state_ff.filt.pixel_clock;
        // Output pulses last a single cycle unless refreshed below.
        nxt_state.valid = 1'b0;
        nxt_state.fstart = 1'b0;
        if (px_edge)
        begin
            // Sync and enable edges are judged between consecutive pixel
            // clocks, so each must stand for a full pixel clock to count.
            nxt_state.last_px = p;
            line_edge = p.line_sync & ~state_ff.last_px.line_sync;
            frame_edge = p.frame_sync & ~state_ff.last_px.frame_sync;
            enable_rise = p.display_enable_strobe
                & ~state_ff.last_px.display_enable_strobe;
            // Pixel counter: the clock carrying the sync edge is clock 0.
            if (line_edge)
            begin
                // A new line always rewinds the horizontal state.
                nxt_state.h_cnt = '0; // [RULE16]
                nxt_state.hstate = prp_pkg::PRP_WAIT_START;
                // The line count saturates, so a host that stops sending
                // frame sync cannot bring the active band round again.
                if (state_ff.v_cnt != prp_pkg::COUNT_MAX)
                begin
                    nxt_state.v_cnt = state_ff.v_cnt + 10'h001;
                end
            end
            else if (state_ff.h_cnt != prp_pkg::COUNT_MAX)
            begin
                // Saturate rather than wrap: an over-long line must not
                // reach the default start clock a second time.
                nxt_state.h_cnt = state_ff.h_cnt + 10'h001;
            end
            // Line counter restarts on frame sync, even mid-line. Frame
            // sync wins over a line sync taken on the same pixel clock.
            if (frame_edge)
            begin
                nxt_state.v_cnt = '0; // [RULE16]
                nxt_state.fstart = 1'b1;
            end
            // Lines outside the active band still run the horizontal
            // logic, but their pixels are never flagged valid.
            v_active = (nxt_state.v_cnt >= prp_pkg::FIRST_ACTIVE_LINE)
                && (nxt_state.v_cnt < prp_pkg::END_ACTIVE_LINE); // [RULE9]
            // Start on the enable edge, or at the default clock if the
            // enable has not risen by then (held low, or too late). An
            // enable rising exactly at the default clock starts the same.
            start_now = (nxt_state.hstate == prp_pkg::PRP_WAIT_START)
                && (enable_rise // [RULE12]
                || nxt_state.h_cnt
                == prp_pkg::DEFAULT_START_CLOCK); // [RULE13] [RULE14]
            // Horizontal state: wait for a start, draw a run, then rest.
            unique case (nxt_state.hstate)
                prp_pkg::PRP_WAIT_START:
                begin
                    // The first pixel leaves as x zero; the run counter
                    // already points at the second.
                    if (start_now)
                    begin
                        nxt_state.x_cnt = 10'h001;
                        nxt_state.hstate = prp_pkg::PRP_DRAWING;
                        nxt_state.valid = v_active;
                        nxt_state.data = p.rgb; // [RULE15]
                        nxt_state.pos = '{x: '0, y: nxt_state.v_cnt
                            - prp_pkg::FIRST_ACTIVE_LINE};
                    end
                end
                prp_pkg::PRP_DRAWING:
                begin
                    // A fixed run of pixels follows the start; the enable
                    // falling early does not cut the line short.
                    nxt_state.valid = v_active;
                    nxt_state.data = p.rgb; // [RULE15]
                    nxt_state.pos = '{x: state_ff.x_cnt, y: nxt_state.v_cnt
                        - prp_pkg::FIRST_ACTIVE_LINE};
                    nxt_state.x_cnt = state_ff.x_cnt + 10'h001;
                    if (state_ff.x_cnt == prp_pkg::LAST_PIXEL)
                    begin
                        nxt_state.hstate = prp_pkg::PRP_LINE_DONE; // [RULE7]
                    end
                end
                prp_pkg::PRP_LINE_DONE:
                begin
                    // Idle until the next line sync; an enable edge seen
                    // here belongs to a line that is already drawn.
                    nxt_state.hstate = prp_pkg::PRP_LINE_DONE;
                end
                default:
                begin
                    // The unused state code parks the line until the
                    // next line sync instead of drawing garbage.
                    nxt_state.hstate = prp_pkg::PRP_LINE_DONE;
                end
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // The line and pixel counters reset to their saturated values so
    // nothing is drawn before the first syncs arrive. Only constants
    // are loaded here; the pins are first looked at once reset has
    // gone, and then only through the capture stages.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= '{
                h_cnt: prp_pkg::COUNT_MAX,
                v_cnt: prp_pkg::COUNT_MAX,
                hstate: prp_pkg::PRP_LINE_DONE,
                default: '0
            };
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from the state flops. They change only on
    // core_clk, so logic downstream needs no further capture.
    assign pixel_valid = state_ff.valid;
    assign pixel_data = state_ff.data;
    assign pixel_pos = state_ff.pos;
    assign frame_start = state_ff.fstart;

endmodule
`default_nettype wire

// [prp_pkg.sv]
// ****************************************************************
// Panel timing receiver shared definitions
// ****************************************************************
package prp_pkg;

    // Colour depth and panel geometry.
    localparam int COLOUR_BITS = 6;
    localparam int PIXELS_PER_LINE = 640;
    localparam int ACTIVE_LINES = 480;
    localparam int COUNT_BITS = 10;

    // Horizontal and vertical placement of the active area.
    localparam logic [9:0] DEFAULT_START_CLOCK = 10'h068;
    localparam logic [9:0] LAST_PIXEL = 10'(PIXELS_PER_LINE - 1);
    localparam logic [9:0] FIRST_ACTIVE_LINE = 10'h022;
    localparam logic [9:0] END_ACTIVE_LINE = 10'(34 + ACTIVE_LINES);
    localparam logic [9:0] COUNT_MAX = 10'h3FF;

    // Host timing limits, kept for reference by the host side.
    localparam real PIXEL_CLOCK_NOM_MHZ = 25.18;
    localparam real PIXEL_CLOCK_MAX_MHZ = 28.33;
    localparam int LINE_PERIOD_MIN = 750;
    localparam int LINE_PERIOD_NOM = 800;
    localparam int LINE_PERIOD_MAX = 900;
    localparam int LINE_SYNC_WIDTH_MIN = 2;
    localparam int LINE_SYNC_WIDTH_NOM = 96;
    localparam int LINE_SYNC_WIDTH_MAX = 200;
    localparam int FRAME_LINES_MIN = 515;
    localparam int FRAME_LINES_NOM = 525;
    localparam int FRAME_LINES_MAX = 560;
    localparam int FRAME_SYNC_WIDTH_MIN = 1;
    localparam int FRAME_SYNC_WIDTH_MAX = 34;
    localparam int FRAME_RATE_MIN_HZ = 50;
    localparam int FRAME_RATE_NOM_HZ = 60;
    localparam int ENABLE_WIDTH_MIN = 2;
    localparam int ENABLE_TAIL = 10;
    localparam int ENABLE_DELAY_MIN = 44;
    localparam int ENABLE_DELAY_TAIL = 664;

    // One pixel: six bits each, bit 0 least significant.
    typedef struct packed {
        logic [COLOUR_BITS-1:0] red_bits;
        logic [COLOUR_BITS-1:0] green_bits;
        logic [COLOUR_BITS-1:0] blue_bits;
    } prp_rgb_t;

    // All panel input pins as one bundle.
    typedef struct packed {
        logic pixel_clock;
        logic line_sync;
        logic frame_sync;
        logic display_enable_strobe;
        prp_rgb_t rgb;
    } prp_pins_t;

    // Position of an accepted pixel.
    typedef struct packed {
        logic [COUNT_BITS-1:0] x;
        logic [COUNT_BITS-1:0] y;
    } prp_pos_t;

    typedef enum logic [1:0] {
        PRP_WAIT_START,
        PRP_DRAWING,
        PRP_LINE_DONE
    } prp_hstate_t;

endpackage

// [prp_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module prp_monitor (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire prp_pkg::prp_pins_t pins,
    input wire logic pixel_valid,
    input wire prp_pkg::prp_pos_t pixel_pos,
    input wire logic frame_start
);
    logic [9:0] last_x_ff;
    logic [9:0] last_y_ff;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Last accepted position, so each pixel can be tied to its neighbour.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_x_ff <= 10'h000;
            last_y_ff <= 10'h000;
        end
        else if (pixel_valid)
        begin
            last_x_ff <= pixel_pos.x;
            last_y_ff <= pixel_pos.y;
        end
    end
    // Frame sync lasts a whole line, so it still stands at frame start;
    // line sync may lead it, so only frame sync is looked at.
    property p_fs_src; frame_start |-> pins.frame_sync; endproperty
    a_fs_src: assert property (p_fs_src)
        else $error("stray frame start");
    property p_fs_once; frame_start |=> !frame_start [*8]; endproperty
    a_fs_once: assert property (p_fs_once)
        else $error("frame start twice");
    // Pixels follow pixel clocks, which are several core cycles apart.
    property p_v_gap; pixel_valid |=> !pixel_valid [*2]; endproperty
    a_v_gap: assert property (p_v_gap)
        else $error("pixels too close");
    property p_v_src; pixel_valid |-> $past(pins.pixel_clock, 3); endproperty
    a_v_src: assert property (p_v_src)
        else $error("pixel without clock");
    // Within a line x steps by one and y holds.
    property p_x_step; pixel_valid && pixel_pos.x != 10'h000
        |-> pixel_pos.x == last_x_ff + 10'h001; endproperty
    a_x_step: assert property (p_x_step)
        else $error("x skipped");
    property p_x_max; pixel_valid |-> pixel_pos.x <= prp_pkg::LAST_PIXEL;
    endproperty
    a_x_max: assert property (p_x_max)
        else $error("x past line end");
    property p_y_max; pixel_valid |-> pixel_pos.y < 10'h1E0; endproperty
    a_y_max: assert property (p_y_max)
        else $error("y past last line");
    property p_y_hold; pixel_valid && pixel_pos.x != 10'h000
        |-> pixel_pos.y == last_y_ff; endproperty
    a_y_hold: assert property (p_y_hold)
        else $error("y moved in line");
endmodule
bind prp_panel_rx prp_monitor i_prp_monitor (.core_clk(core_clk),
    .rst_n(rst_n), .pins(pins), .pixel_valid(pixel_valid),
    .pixel_pos(pixel_pos), .frame_start(frame_start));
`default_nettype wire

// [prp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// Host controller model
// ****
module prp_host_model (
    input wire logic core_clk,
    output var prp_pkg::prp_pins_t pins
);
    // Everything idles low until the first line; between calls the
    // pixel clock stands high.
    initial
        pins = '0;
    // One line: each pixel clock is 3 core cycles low then 3 high, far
    // below the real rate because the receiver filters every pin. Data,
    // syncs and enable change with the falling pixel clock, so they are
    // settled well before the rising edge that samples them. Frame sync
    // covers the whole first line of a frame, starting with line sync.
    task automatic send_line(input int per, input int en, input bit fs,
        input int l);
        for (int k = 0; k < per; k++)
        begin
            @(posedge core_clk);
            #1;
            pins.pixel_clock = 1'b0;
            pins.line_sync = k < 96;
            pins.frame_sync = fs;
            pins.display_enable_strobe = en > 0 && k >= en
                && k < en + 640;
            pins.rgb = 18'(l * 1024 + k);
            repeat (3) @(posedge core_clk);
            #1;
            pins.pixel_clock = 1'b1;
            repeat (2) @(posedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    prp_pkg::prp_pins_t pins;
    logic pixel_valid;
    logic frame_start;
    prp_pkg::prp_rgb_t pixel_data;
    prp_pkg::prp_pos_t pixel_pos;
    prp_pkg::prp_rgb_t f_rgb;
    prp_pkg::prp_rgb_t l_rgb;
    prp_pkg::prp_pos_t f_pos;
    prp_pkg::prp_pos_t l_pos;
    int errors = 0;
    int comparisons = 0;
    int seen = 0;
    int starts = 0;
    prp_host_model i_prp_host_model (.core_clk(core_clk), .pins(pins));
    prp_panel_rx i_prp_panel_rx (.core_clk(core_clk), .rst_n(rst_n),
        .pins(pins), .pixel_valid(pixel_valid), .pixel_data(pixel_data),
        .pixel_pos(pixel_pos), .frame_start(frame_start));
    // Free-running core clock.
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end
    // Collect first and last accepted pixel of the line under test.
    always @(posedge core_clk)
    begin
        if (pixel_valid === 1'b1)
        begin
            if (seen == 0)
            begin
                f_rgb = pixel_data;
                f_pos = pixel_pos;
            end
            l_rgb = pixel_data;
            l_pos = pixel_pos;
            seen++;
        end
        if (frame_start === 1'b1)
            starts++;
    end
    task automatic check(input string what, input logic [19:0] exp,
        input logic [19:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Blank lines are cut to 120 clocks to keep the run short; only the
    // line count matters before the active area. Frames are thus far
    // shorter and faster than a real host sends them; the receiver only
    // counts lines and never judges frame length or rate. n is the
    // number of frame starts expected once the blank lines are sent.
    task automatic t_blank(input int n);
        seen = 0;
        i_prp_host_model.send_line(120, 0, 1'b1, 0);
        for (int l = 1; l < 34; l++)
            i_prp_host_model.send_line(120, 0, 1'b0, l);
        check("frame starts", 20'(n), 20'(starts));
        check("blank pixels", 20'h00000, 20'(seen));
        $display("test blank lines done");
    endtask
    // Full line of 800 clocks; st is the clock of the first pixel.
    task automatic active(input int l, input int en, input int st);
        seen = 0;
        i_prp_host_model.send_line(800, en, 1'b0, l);
        check("count", 20'h00280, 20'(seen));
        check("first rgb", 20'(l * 1024 + st), 20'(f_rgb));
        check("last rgb", 20'(l * 1024 + st + 639), 20'(l_rgb));
        check("first pos", {10'h000, 10'(l - 34)}, f_pos);
        check("last pos", {10'h27F, 10'(l - 34)}, l_pos);
    endtask
    task automatic t_low();
        active(34, 0, 104);
        $display("test enable low done");
    endtask
    task automatic t_early();
        active(35, 44, 44);
        $display("test early enable done");
    endtask
    // Runs in the second frame: y of zero shows the line count restarted.
    task automatic t_late();
        active(34, 120, 104);
        $display("test late enable done");
    endtask
    // Hang guard.
    initial
    begin
        #8000000;
        errors++;
        wrap_up();
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        t_blank(1);
        t_low();
        t_early();
        t_blank(2);
        t_late();
        wrap_up();
    end
endmodule
`default_nettype wire
